// file: logic/uefa_pkg.sv
package uefa_pkg;
	// Endpoint and FIFO geometry
	localparam int NUM_EP = 5;
	localparam int NUM_FIFO = 10;
	localparam int FIFO_BYTES = 64;
	localparam int PTR_W = 6;
	localparam int IDX_W = 4;
	localparam int MEM_AW = 10;
	localparam int SIZE_W = 7;
	localparam int SETUP_BYTES = 8;
	localparam int SETUP_FIFO_DEPTH = 16;
	localparam int SETUP_FIFO_W = 9;
	// Special-function register offsets
	localparam logic [7:0] OFS_DEV_ADDR = 8'he2;
	localparam logic [7:0] OFS_PAIR = 8'he3;
	localparam logic [7:0] OFS_GLOBAL_IE = 8'he4;
	localparam logic [7:0] OFS_IN_IE = 8'he5;
	localparam logic [7:0] OFS_OUT_IE = 8'he6;
	localparam logic [7:0] OFS_NAK_IE = 8'he7;
	localparam logic [7:0] OFS_GLOBAL_FLAG = 8'he8;
	localparam logic [7:0] OFS_IN_FLAG = 8'he9;
	localparam logic [7:0] OFS_OUT_FLAG = 8'hea;
	localparam logic [7:0] OFS_NAK_FLAG = 8'heb;
	localparam logic [7:0] OFS_EP_SEL = 8'hf0;
	localparam logic [7:0] OFS_EP_CTRL = 8'hf1;
	localparam logic [7:0] OFS_EP_SIZE = 8'hf2;
	localparam logic [7:0] OFS_SETUP_IDX = 8'hf3;
	localparam logic [7:0] OFS_SETUP_VAL = 8'hf4;
	localparam logic [7:0] OFS_BASE_HI = 8'hf5;
	localparam logic [7:0] OFS_BASE_LO = 8'hf6;
	localparam logic [7:0] OFS_WIN_CTRL = 8'hf7;
	// Field positions
	localparam int SEL_DIR_POS = 7;
	localparam int PAIR_IN_1_2_POS = 0;
	localparam int PAIR_IN_3_4_POS = 1;
	localparam int WIN_EXPOSE_POS = 0;
	localparam logic DIR_IN = 1'b1;
	// Writable masks and reset values
	localparam logic [7:0] DEV_ADDR_MASK = 8'h7f;
	localparam logic [7:0] PAIR_MASK = 8'h0f;
	localparam logic [7:0] GLOBAL_MASK = 8'h0f;
	localparam logic [7:0] EP_MASK = 8'h1f;
	localparam logic [7:0] SEL_MASK = 8'h87;
	localparam logic [7:0] SETUP_IDX_MASK = 8'h07;
	localparam logic [7:0] BASE_LO_MASK = 8'hc0;
	localparam logic [7:0] REG_RESET = 8'h00;
endpackage

// file: logic/uefa_sync_fifo.sv
`timescale 1ns/1ps
module uefa_sync_fifo #(
	parameter int W = 9,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
		logic rdy;
	} uefa_fifo_s;

	uefa_fifo_s s_reg;
	uefa_fifo_s s_next;
	logic push;
	logic pop;

	assign push = in_valid && s_reg.rdy;
	assign pop = out_valid && out_ready;
	assign out_valid = s_reg.cnt != '0;
	assign out_data = s_reg.mem[s_reg.rp];
	assign in_ready = s_reg.rdy;

	always_comb
	begin
		s_next = s_reg;
		if (push)
		begin
			s_next.mem[s_reg.wp] = in_data;
			s_next.wp = AW'(s_reg.wp + 1'b1);
		end
		if (pop)
			s_next.rp = AW'(s_reg.rp + 1'b1);
		s_next.cnt = CW'(s_reg.cnt + CW'(push) - CW'(pop));
		// Ready is registered so the source sees it from a flop
		s_next.rdy = s_next.cnt < CW'(DEPTH);
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			s_reg <= '0;
			s_reg.rdy <= 1'b1;
		end
		else
			s_reg <= s_next;
	end
endmodule // uefa_sync_fifo

// file: logic/uefa_fifo_ram.sv
`timescale 1ns/1ps
module uefa_fifo_ram #(
	parameter int DW = 8,
	parameter int AW = 10,
	parameter int DEPTH = 640
) (
	// Clock
	input wire logic core_clk,
	// Port A, processor window
	input wire logic a_we,
	input wire logic [AW-1:0] a_addr,
	input wire logic [DW-1:0] a_wdata,
	output logic [DW-1:0] a_rdata,
	// Port B, serial engine
	input wire logic b_we,
	input wire logic [AW-1:0] b_addr,
	input wire logic [DW-1:0] b_wdata,
	output logic [DW-1:0] b_rdata
);
	logic [DW-1:0] mem [DEPTH];

	// Serial engine write is issued last so it wins a same-address clash
	always_ff @(posedge core_clk)
	begin
		if (a_we && a_addr < AW'(DEPTH))
			mem[a_addr] <= a_wdata;
		if (b_we && b_addr < AW'(DEPTH))
			mem[b_addr] <= b_wdata;
		a_rdata <= (a_addr < AW'(DEPTH)) ? mem[a_addr] : '0;
		b_rdata <= (b_addr < AW'(DEPTH)) ? mem[b_addr] : '0;
	end
endmodule // uefa_fifo_ram

// file: logic/uefa_endpoint_access.sv
`timescale 1ns/1ps
module uefa_endpoint_access #(
	parameter int SETUP_DEPTH = uefa_pkg::SETUP_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Special-function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// External data space port
	input wire logic [15:0] xd_addr,
	input wire logic xd_wr,
	input wire logic xd_rd,
	input wire logic [7:0] xd_wdata,
	output logic [7:0] xd_rdata,
	output logic xd_hit,
	// Serial engine FIFO port
	input wire logic [2:0] sie_ep,
	input wire logic sie_dir,
	input wire logic [5:0] sie_ptr,
	input wire logic sie_wr,
	input wire logic [7:0] sie_wdata,
	output logic [7:0] sie_rdata,
	// Serial engine size updates and tokens
	input wire logic sie_size_wr,
	input wire logic [6:0] sie_size_val,
	input wire logic sie_in_token,
	input wire logic [3:0] sie_bus_evt,
	output logic in_nak,
	output logic [2:0] in_nak_ep,
	// Setup byte stream
	input wire logic setup_valid,
	input wire logic setup_first,
	input wire logic [7:0] setup_data,
	output logic setup_ready,
	// Interrupt request
	output logic usb_irq
);
	typedef struct packed {
		logic [7:0] dev_addr;
		logic [7:0] pair;
		logic [7:0] global_ie;
		logic [7:0] in_ie;
		logic [7:0] out_ie;
		logic [7:0] nak_ie;
		logic [7:0] sel;
		logic [7:0] setup_idx;
		logic [7:0] base_hi;
		logic [7:0] base_lo;
		logic expose;
		logic [3:0] global_flag;
		logic [4:0] in_flag;
		logic [4:0] out_flag;
		logic [4:0] nak_flag;
		logic [9:0][7:0] ctrl;
		logic [9:0][6:0] size;
		logic [7:0][7:0] setup;
		logic [2:0] setup_wptr;
		logic [7:0] rdata;
		logic hit;
		logic irq;
		logic nak;
		logic [2:0] nak_ep;
	} uefa_state_s;

	uefa_state_s s_reg;
	uefa_state_s s_next;

	function automatic logic [3:0] fifo_idx(input logic [2:0] ep, input logic dir);
		fifo_idx = {ep, dir};
	endfunction

	function automatic logic ep_ok(input logic [2:0] ep);
		ep_ok = ep < 3'(uefa_pkg::NUM_EP);
	endfunction

	// Keep mask for a write-zero-to-clear flag register
	function automatic logic [4:0] keep_mask(input logic wr, input logic [7:0] a,
		input logic [7:0] ofs, input logic [7:0] d);
		keep_mask = (wr && a == ofs) ? d[4:0] : 5'h1f;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Window decode and FIFO storage

	logic [2:0] sel_ep;
	logic sel_dir;
	logic [3:0] sel_idx;
	logic win_hit;
	logic setup_take;
	logic [8:0] setup_word;

	assign sel_ep = s_reg.sel[2:0];
	assign sel_dir = s_reg.sel[uefa_pkg::SEL_DIR_POS];
	assign sel_idx = fifo_idx(sel_ep, sel_dir);
	assign win_hit = s_reg.expose && ep_ok(sel_ep)
		&& xd_addr[15:6] == {s_reg.base_hi, s_reg.base_lo[7:6]};

	uefa_fifo_ram #(
		.DW(8),
		.AW(uefa_pkg::MEM_AW),
		.DEPTH(uefa_pkg::NUM_FIFO * uefa_pkg::FIFO_BYTES)
	) u_ram (
		.core_clk(core_clk),
		.a_we(xd_wr && win_hit),
		.a_addr({sel_idx, xd_addr[5:0]}),
		.a_wdata(xd_wdata),
		.a_rdata(xd_rdata),
		.b_we(sie_wr),
		.b_addr({fifo_idx(sie_ep, sie_dir), sie_ptr}),
		.b_wdata(sie_wdata),
		.b_rdata(sie_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Setup byte stream

	uefa_sync_fifo #(
		.W(uefa_pkg::SETUP_FIFO_W),
		.DEPTH(SETUP_DEPTH)
	) u_setup_fifo (
		.core_clk(core_clk),
		.resetn(resetn),
		.in_valid(setup_valid),
		.in_data({setup_first, setup_data}),
		.in_ready(setup_ready),
		.out_valid(setup_take),
		.out_data(setup_word),
		.out_ready(!(sfr_rd && sfr_addr == uefa_pkg::OFS_SETUP_VAL))
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register file and event logic

	always_comb
	begin
		logic [4:0] in_set;
		logic [4:0] pair_keep;
		logic [2:0] wp;
		logic drain;
		logic [4:0] gkeep;
		in_set = '0;
		gkeep = keep_mask(sfr_wr, sfr_addr, uefa_pkg::OFS_GLOBAL_FLAG, sfr_wdata);
		pair_keep = '1;
		wp = '0;
		drain = setup_take && !(sfr_rd && sfr_addr == uefa_pkg::OFS_SETUP_VAL);
		s_next = s_reg;
		s_next.nak = 1'b0;
		if (sfr_wr)
		begin
			case (sfr_addr)
				uefa_pkg::OFS_DEV_ADDR: s_next.dev_addr = sfr_wdata & uefa_pkg::DEV_ADDR_MASK;
				uefa_pkg::OFS_PAIR: s_next.pair = sfr_wdata & uefa_pkg::PAIR_MASK;
				uefa_pkg::OFS_GLOBAL_IE: s_next.global_ie = sfr_wdata & uefa_pkg::GLOBAL_MASK;
				uefa_pkg::OFS_IN_IE: s_next.in_ie = sfr_wdata & uefa_pkg::EP_MASK;
				uefa_pkg::OFS_OUT_IE: s_next.out_ie = sfr_wdata & uefa_pkg::EP_MASK;
				uefa_pkg::OFS_NAK_IE: s_next.nak_ie = sfr_wdata & uefa_pkg::EP_MASK;
				uefa_pkg::OFS_EP_SEL: s_next.sel = sfr_wdata & uefa_pkg::SEL_MASK;
				uefa_pkg::OFS_EP_CTRL:
					if (ep_ok(sel_ep))
						s_next.ctrl[sel_idx] = sfr_wdata;
				uefa_pkg::OFS_EP_SIZE:
					if (ep_ok(sel_ep))
						s_next.size[sel_idx] = sfr_wdata[6:0];
				uefa_pkg::OFS_SETUP_IDX: s_next.setup_idx = sfr_wdata & uefa_pkg::SETUP_IDX_MASK;
				uefa_pkg::OFS_BASE_HI: s_next.base_hi = sfr_wdata;
				uefa_pkg::OFS_BASE_LO: s_next.base_lo = sfr_wdata & uefa_pkg::BASE_LO_MASK;
				uefa_pkg::OFS_WIN_CTRL: s_next.expose = sfr_wdata[uefa_pkg::WIN_EXPOSE_POS];
				default: ;
			endcase
		end
		// Serial engine size update lands after firmware's, so it wins a clash
		if (sie_size_wr && ep_ok(sie_ep))
			s_next.size[fifo_idx(sie_ep, sie_dir)] = sie_size_val;
		// Full-to-empty on each IN FIFO
		for (int e = 0; e < uefa_pkg::NUM_EP; e++)
			in_set[e] = s_reg.size[2 * e + 1] != '0 && s_next.size[2 * e + 1] == '0;
		pair_keep[2] = !s_reg.pair[uefa_pkg::PAIR_IN_1_2_POS];
		pair_keep[4] = !s_reg.pair[uefa_pkg::PAIR_IN_3_4_POS];
		// Set wins over a same-cycle clear
		s_next.in_flag = ((s_reg.in_flag
			& keep_mask(sfr_wr, sfr_addr, uefa_pkg::OFS_IN_FLAG, sfr_wdata))
			| in_set) & pair_keep;
		s_next.out_flag = s_reg.out_flag
			& keep_mask(sfr_wr, sfr_addr, uefa_pkg::OFS_OUT_FLAG, sfr_wdata);
		if (sie_size_wr && ep_ok(sie_ep) && sie_dir != uefa_pkg::DIR_IN && sie_size_val != '0)
			s_next.out_flag[sie_ep] = 1'b1;
		s_next.nak_flag = s_reg.nak_flag
			& keep_mask(sfr_wr, sfr_addr, uefa_pkg::OFS_NAK_FLAG, sfr_wdata);
		s_next.global_flag = (s_reg.global_flag & gkeep[3:0]) | sie_bus_evt;
		// IN token against an empty IN FIFO is refused
		if (sie_in_token && ep_ok(sie_ep) && s_reg.size[fifo_idx(sie_ep, 1'b1)] == '0)
		begin
			s_next.nak = 1'b1;
			s_next.nak_ep = sie_ep;
			s_next.nak_flag[sie_ep] = 1'b1;
		end
		// Setup bytes fill the command buffer from slot zero on a new packet
		if (drain)
		begin
			wp = setup_word[8] ? 3'h0 : s_reg.setup_wptr;
			s_next.setup[wp] = setup_word[7:0];
			s_next.setup_wptr = 3'(wp + 3'h1);
		end
		s_next.hit = xd_rd && win_hit;
		s_next.irq = |{s_next.global_flag & s_reg.global_ie[3:0],
			s_next.in_flag & s_reg.in_ie[4:0], s_next.out_flag & s_reg.out_ie[4:0],
			s_next.nak_flag & s_reg.nak_ie[4:0]};
		s_next.rdata = s_reg.rdata;
		if (sfr_rd)
		begin
			case (sfr_addr)
				uefa_pkg::OFS_DEV_ADDR: s_next.rdata = s_reg.dev_addr;
				uefa_pkg::OFS_PAIR: s_next.rdata = s_reg.pair;
				uefa_pkg::OFS_GLOBAL_IE: s_next.rdata = s_reg.global_ie;
				uefa_pkg::OFS_IN_IE: s_next.rdata = s_reg.in_ie;
				uefa_pkg::OFS_OUT_IE: s_next.rdata = s_reg.out_ie;
				uefa_pkg::OFS_NAK_IE: s_next.rdata = s_reg.nak_ie;
				uefa_pkg::OFS_GLOBAL_FLAG: s_next.rdata = {4'h0, s_reg.global_flag};
				uefa_pkg::OFS_IN_FLAG: s_next.rdata = {3'h0, s_reg.in_flag};
				uefa_pkg::OFS_OUT_FLAG: s_next.rdata = {3'h0, s_reg.out_flag};
				uefa_pkg::OFS_NAK_FLAG: s_next.rdata = {3'h0, s_reg.nak_flag};
				uefa_pkg::OFS_EP_SEL: s_next.rdata = s_reg.sel;
				uefa_pkg::OFS_EP_CTRL:
					s_next.rdata = ep_ok(sel_ep) ? s_reg.ctrl[sel_idx] : 8'h00;
				uefa_pkg::OFS_EP_SIZE:
					s_next.rdata = ep_ok(sel_ep) ? {1'b0, s_reg.size[sel_idx]} : 8'h00;
				uefa_pkg::OFS_SETUP_IDX: s_next.rdata = s_reg.setup_idx;
				uefa_pkg::OFS_SETUP_VAL: s_next.rdata = s_reg.setup[s_reg.setup_idx[2:0]];
				uefa_pkg::OFS_BASE_HI: s_next.rdata = s_reg.base_hi;
				uefa_pkg::OFS_BASE_LO: s_next.rdata = s_reg.base_lo;
				uefa_pkg::OFS_WIN_CTRL: s_next.rdata = {7'h00, s_reg.expose};
				default: s_next.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign sfr_rdata = s_reg.rdata;
	assign xd_hit = s_reg.hit;
	assign in_nak = s_reg.nak;
	assign in_nak_ep = s_reg.nak_ep;
	assign usb_irq = s_reg.irq;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	a_nak_on_empty: assert property (@(posedge core_clk) disable iff (!resetn)
		sie_in_token && sie_ep == 3'h2 && s_reg.size[5] == '0 |=> in_nak && in_nak_ep == 3'h2)
		else $error("IN token on empty FIFO not refused");

	a_no_nak_loaded: assert property (@(posedge core_clk) disable iff (!resetn)
		sie_in_token && sie_ep == 3'h3 && s_reg.size[7] != '0 |=> !in_nak)
		else $error("IN token on loaded FIFO refused");

	a_window_closed: assert property (@(posedge core_clk) disable iff (!resetn)
		!s_reg.expose && xd_rd |=> !xd_hit)
		else $error("FIFO window answered while hidden");

	a_ctrl_steered: assert property (@(posedge core_clk) disable iff (!resetn)
		sfr_rd && sfr_addr == uefa_pkg::OFS_EP_CTRL && s_reg.sel == 8'h03
		|=> sfr_rdata == $past(s_reg.ctrl[6]))
		else $error("Control read not steered by select");

	a_setup_value: assert property (@(posedge core_clk) disable iff (!resetn)
		sfr_rd && sfr_addr == uefa_pkg::OFS_SETUP_VAL && s_reg.setup_idx == 8'h05
		|=> sfr_rdata == $past(s_reg.setup[5]))
		else $error("Setup value read wrong byte");

	a_in_flag_set: assert property (@(posedge core_clk) disable iff (!resetn)
		s_reg.size[1] != '0 ##1 s_reg.size[1] == '0 |-> s_reg.in_flag[0])
		else $error("IN flag missed full to empty");

	a_in_flag_hold: assert property (@(posedge core_clk) disable iff (!resetn)
		s_reg.in_flag[1] && !(sfr_wr && sfr_addr == uefa_pkg::OFS_IN_FLAG && !sfr_wdata[1])
		|=> s_reg.in_flag[1])
		else $error("IN flag dropped without clear");

	a_pair_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
		s_reg.pair[uefa_pkg::PAIR_IN_1_2_POS] |=> !s_reg.in_flag[2])
		else $error("Even IN flag active while paired");

	a_irq_level: assert property (@(posedge core_clk) disable iff (!resetn)
		usb_irq == |{s_reg.in_flag & $past(s_reg.in_ie[4:0]),
		s_reg.global_flag & $past(s_reg.global_ie[3:0]),
		s_reg.out_flag & $past(s_reg.out_ie[4:0]), s_reg.nak_flag & $past(s_reg.nak_ie[4:0])})
		else $error("Interrupt request disagrees with flags");

	a_setup_store: assert property (@(posedge core_clk) disable iff (!resetn)
		setup_take && setup_word[8] && !(sfr_rd && sfr_addr == uefa_pkg::OFS_SETUP_VAL)
		|=> s_reg.setup[0] == $past(setup_word[7:0]) && s_reg.setup_wptr == 3'h1)
		else $error("First setup byte not stored in slot zero");
endmodule // uefa_endpoint_access

// file: bench/uefa_host_model.sv
`timescale 1ns/1ps
module uefa_host_model (
	// Clock
	input wire logic core_clk,
	// Serial engine lines
	output logic [2:0] sie_ep,
	output logic sie_dir,
	output logic [5:0] sie_ptr,
	output logic sie_wr,
	output logic [7:0] sie_wdata,
	output logic sie_size_wr,
	output logic [6:0] sie_size_val,
	output logic sie_in_token,
	output logic [3:0] sie_bus_evt,
	// Setup byte stream
	output logic setup_valid,
	output logic setup_first,
	output logic [7:0] setup_data,
	input wire logic setup_ready
);
	int accepted = 0;
	initial
	begin
		{sie_ep, sie_dir, sie_ptr, sie_wr, sie_size_wr, sie_size_val} = '0;
		{sie_in_token, sie_bus_evt, setup_valid, setup_first} = '0;
		sie_wdata = 8'h5a;
		setup_data = 8'ha5;
	end
	////////////////////////////////////////////////////////////////////////
	// One request; kind bit0 byte write, bit1 size write, bit2 IN token
	task automatic sie_op(input logic [2:0] ep, input logic dir, input logic [5:0] ptr,
		input logic [2:0] kind, input logic [7:0] d);
		@(posedge core_clk);
		sie_ep <= ep;
		sie_dir <= dir;
		sie_ptr <= ptr;
		sie_wr <= kind[0];
		sie_size_wr <= kind[1];
		sie_size_val <= d[6:0];
		sie_in_token <= kind[2];
		sie_wdata <= kind[0] ? d : ~sie_wdata;
		@(posedge core_clk);
		sie_wr <= 1'b0;
		sie_size_wr <= 1'b0;
		sie_in_token <= 1'b0;
		sie_wdata <= ~sie_wdata;
	endtask
	task automatic bus_event(input logic [3:0] e);
		@(posedge core_clk);
		sie_bus_evt <= e;
		@(posedge core_clk);
		sie_bus_evt <= 4'h0;
	endtask
	// Each byte is held until the block takes it
	task automatic send_setup(input int n, input logic [7:0] base);
		@(posedge core_clk);
		for (int i = 0; i < n; i++)
		begin
			setup_valid <= 1'b1;
			setup_first <= (i == 0);
			setup_data <= base + 8'(i);
			do @(posedge core_clk); while (setup_ready !== 1'b1);
			accepted++;
		end
		setup_valid <= 1'b0;
		setup_first <= 1'b0;
		setup_data <= ~setup_data;
	endtask
endmodule // uefa_host_model

// file: bench/usb_endpoint_fifo_access_tb_top.sv
`timescale 1ns/1ps
module usb_endpoint_fifo_access_tb_top;
	localparam int SETUP_DEPTH = 16;
	localparam logic [15:0] BASE = 16'h4080;
	logic core_clk;
	logic resetn = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [15:0] xd_addr = 16'h0000;
	logic xd_wr = 1'b0;
	logic xd_rd = 1'b0;
	logic [7:0] xd_wdata = 8'h00;
	logic [7:0] sfr_rdata, xd_rdata, sie_wdata, sie_rdata, setup_data;
	logic [2:0] sie_ep, in_nak_ep;
	logic [5:0] sie_ptr;
	logic [6:0] sie_size_val;
	logic [3:0] sie_bus_evt;
	logic xd_hit, sie_dir, sie_wr, sie_size_wr, sie_in_token, in_nak;
	logic setup_valid, setup_first, setup_ready, usb_irq;
	logic rd_d = 1'b0;
	logic xrd_d = 1'b0;
	logic [8:0] es, ex;
	logic [8:0] sfr_q[$];
	logic [8:0] xd_q[$];
	logic [7:0] mem [10][2];
	logic [15:0] regs [6];
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	uefa_endpoint_access #(.SETUP_DEPTH(SETUP_DEPTH)) DUT (.core_clk(core_clk), .resetn(resetn),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .xd_addr(xd_addr), .xd_wr(xd_wr), .xd_rd(xd_rd),
		.xd_wdata(xd_wdata), .xd_rdata(xd_rdata), .xd_hit(xd_hit), .sie_ep(sie_ep),
		.sie_dir(sie_dir), .sie_ptr(sie_ptr), .sie_wr(sie_wr), .sie_wdata(sie_wdata),
		.sie_rdata(sie_rdata), .sie_size_wr(sie_size_wr), .sie_size_val(sie_size_val),
		.sie_in_token(sie_in_token), .sie_bus_evt(sie_bus_evt), .in_nak(in_nak),
		.in_nak_ep(in_nak_ep), .setup_valid(setup_valid), .setup_first(setup_first),
		.setup_data(setup_data), .setup_ready(setup_ready), .usb_irq(usb_irq));
	uefa_host_model host (.core_clk(core_clk), .sie_ep(sie_ep), .sie_dir(sie_dir),
		.sie_ptr(sie_ptr), .sie_wr(sie_wr), .sie_wdata(sie_wdata), .sie_size_wr(sie_size_wr),
		.sie_size_val(sie_size_val), .sie_in_token(sie_in_token), .sie_bus_evt(sie_bus_evt),
		.setup_valid(setup_valid), .setup_first(setup_first), .setup_data(setup_data),
		.setup_ready(setup_ready));
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Register and window bus cycles; a read notes its expected answer
	task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_wr <= wr;
		sfr_rd <= !wr;
		sfr_wdata <= d;
		if (!wr)
			sfr_q.push_back({1'b1, d});
		@(posedge core_clk);
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b0;
	endtask
	task automatic xd(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic hit);
		@(posedge core_clk);
		xd_addr <= a;
		xd_wr <= wr;
		xd_rd <= !wr;
		xd_wdata <= d;
		if (!wr)
			xd_q.push_back({hit, d});
		@(posedge core_clk);
		xd_wr <= 1'b0;
		xd_rd <= 1'b0;
	endtask
	task automatic sel(input logic [3:0] f);
		sfr(1'b1, uefa_pkg::OFS_EP_SEL, {f[0], 4'h0, f[3:1]});
	endtask
	// Result watcher, sampling in mid-cycle
	always @(posedge core_clk)
	begin
		rd_d <= sfr_rd & resetn;
		xrd_d <= xd_rd & resetn;
	end
	always @(negedge core_clk)
	begin
		if (rd_d && sfr_q.size() > 0)
		begin
			es = sfr_q.pop_front();
			if (es[8])
				check({1'b1, sfr_rdata}, es);
		end
		if (xrd_d && xd_q.size() > 0)
		begin
			ex = xd_q.pop_front();
			check({xd_hit, ex[8] ? xd_rdata : ex[7:0]}, ex);
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		regs = '{{uefa_pkg::OFS_DEV_ADDR, uefa_pkg::DEV_ADDR_MASK},
			{uefa_pkg::OFS_PAIR, uefa_pkg::PAIR_MASK}, {uefa_pkg::OFS_GLOBAL_IE, 8'h0f},
			{uefa_pkg::OFS_IN_IE, 8'h1f}, {uefa_pkg::OFS_OUT_IE, 8'h1f},
			{uefa_pkg::OFS_NAK_IE, 8'h1f}};
		void'($urandom(32'h914e));
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			sfr(1'b0, regs[i][15:8], 8'h00);
			sfr(1'b1, regs[i][15:8], 8'hff);
			sfr(1'b0, regs[i][15:8], regs[i][7:0]);
			sfr(1'b1, regs[i][15:8], 8'h00);
		end
		sfr(1'b0, uefa_pkg::OFS_IN_FLAG, 8'h00);
		sfr(1'b1, 8'h80, 8'hff);
		sfr(1'b0, 8'h80, 8'h00);
		$display("test registers done");
		sfr(1'b1, uefa_pkg::OFS_BASE_HI, BASE[15:8]);
		sfr(1'b1, uefa_pkg::OFS_BASE_LO, BASE[7:0]);
		sfr(1'b1, uefa_pkg::OFS_WIN_CTRL, 8'h01);
		for (int f = 0; f < 10; f++)
		begin
			sel(4'(f));
			for (int k = 0; k < 2; k++)
			begin
				mem[f][k] = 8'($urandom);
				xd(1'b1, BASE + 16'(k * 63), mem[f][k], 1'b0);
			end
		end
		for (int f = 0; f < 10; f++)
		begin
			sel(4'(f));
			for (int k = 0; k < 2; k++)
			begin
				xd(1'b0, BASE + 16'(k * 63), mem[f][k], 1'b1);
				host.sie_op(3'(f / 2), f[0], 6'(k * 63), 3'b000, 8'h00);
				@(negedge core_clk);
				check({1'b0, sie_rdata}, {1'b0, mem[f][k]});
			end
		end
		xd(1'b0, BASE + 16'h0040, 8'h00, 1'b0);
		host.sie_op(3'h4, 1'b1, 6'h05, 3'b001, 8'hc3);
		xd(1'b0, BASE + 16'h0005, 8'hc3, 1'b1);
		sfr(1'b1, uefa_pkg::OFS_WIN_CTRL, 8'h00);
		xd(1'b1, BASE, ~mem[9][0], 1'b0);
		xd(1'b0, BASE, 8'h00, 1'b0);
		host.sie_op(3'h4, 1'b1, 6'h00, 3'b000, 8'h00);
		@(negedge core_clk);
		check({1'b0, sie_rdata}, {1'b0, mem[9][0]});
		$display("test window done");
		for (int e = 0; e < 5; e++)
		begin
			sel(4'(e * 2));
			sfr(1'b1, uefa_pkg::OFS_EP_CTRL, 8'h30 + 8'(e));
			sfr(1'b1, uefa_pkg::OFS_EP_SIZE, 8'h01 + 8'(e));
		end
		for (int e = 0; e < 5; e++)
		begin
			sel(4'(e * 2));
			sfr(1'b0, uefa_pkg::OFS_EP_CTRL, 8'h30 + 8'(e));
			sfr(1'b0, uefa_pkg::OFS_EP_SIZE, 8'h01 + 8'(e));
		end
		sfr(1'b1, uefa_pkg::OFS_EP_SEL, 8'h05);
		sfr(1'b0, uefa_pkg::OFS_EP_CTRL, 8'h00);
		$display("test select done");
		sfr(1'b1, uefa_pkg::OFS_NAK_IE, 8'h04);
		host.sie_op(3'h2, 1'b1, 6'h00, 3'b100, 8'h00);
		@(negedge core_clk);
		check({in_nak, 5'h00, in_nak_ep}, 9'h102);
		@(negedge core_clk);
		check({8'h00, usb_irq}, 9'h001);
		host.sie_op(3'h3, 1'b1, 6'h00, 3'b010, 8'h05);
		host.sie_op(3'h3, 1'b1, 6'h00, 3'b100, 8'h00);
		@(negedge core_clk);
		check({8'h00, in_nak}, 9'h000);
		sfr(1'b1, uefa_pkg::OFS_NAK_FLAG, 8'h00);
		@(negedge core_clk);
		check({8'h00, usb_irq}, 9'h000);
		sfr(1'b1, uefa_pkg::OFS_NAK_IE, 8'h00);
		sfr(1'b1, uefa_pkg::OFS_IN_IE, 8'h18);
		sfr(1'b1, uefa_pkg::OFS_PAIR, 8'h03);
		host.sie_op(3'h3, 1'b1, 6'h00, 3'b010, 8'h00);
		host.sie_op(3'h4, 1'b1, 6'h00, 3'b010, 8'h09);
		host.sie_op(3'h4, 1'b1, 6'h00, 3'b010, 8'h00);
		sfr(1'b0, uefa_pkg::OFS_IN_FLAG, 8'h08);
		@(negedge core_clk);
		check({8'h00, usb_irq}, 9'h001);
		sfr(1'b1, uefa_pkg::OFS_IN_FLAG, 8'hff);
		sfr(1'b0, uefa_pkg::OFS_IN_FLAG, 8'h08);
		sfr(1'b1, uefa_pkg::OFS_IN_FLAG, 8'h00);
		sfr(1'b0, uefa_pkg::OFS_IN_FLAG, 8'h00);
		@(negedge core_clk);
		check({8'h00, usb_irq}, 9'h000);
		sfr(1'b1, uefa_pkg::OFS_PAIR, 8'h00);
		host.sie_op(3'h4, 1'b1, 6'h00, 3'b010, 8'h09);
		host.sie_op(3'h4, 1'b1, 6'h00, 3'b010, 8'h00);
		sfr(1'b0, uefa_pkg::OFS_IN_FLAG, 8'h10);
		host.bus_event(4'hf);
		sfr(1'b0, uefa_pkg::OFS_GLOBAL_FLAG, 8'h0f);
		$display("test flags done");
		// Setup value reads stall the drain, so the stream fills the setup FIFO
		fork
			begin
				repeat (30)
				begin
					@(posedge core_clk);
					sfr_addr <= uefa_pkg::OFS_SETUP_VAL;
					sfr_rd <= 1'b1;
					sfr_q.push_back(9'h000);
				end
				@(posedge core_clk);
				sfr_rd <= 1'b0;
				check(9'(host.accepted), 9'(SETUP_DEPTH));
			end
			host.send_setup(20, 8'h50);
		join
		repeat (40) @(posedge core_clk);
		for (int i = 0; i < 8; i++)
		begin
			sfr(1'b1, uefa_pkg::OFS_SETUP_IDX, 8'(i));
			sfr(1'b0, uefa_pkg::OFS_SETUP_VAL, 8'h50 + 8'(i < 4 ? 16 + i : 8 + i));
		end
		@(negedge core_clk);
		check({8'h00, setup_ready}, 9'h001);
		$display("test setup done");
		repeat (4) @(posedge core_clk);
		print_verdict();
	end
endmodule // usb_endpoint_fifo_access_tb_top
